// [ccs_pkg.sv]
package ccs_pkg;

  // ----------------------------------------
  // attribute memory map and drive address slot index
  // ----------------------------------------
  localparam logic [10:0] CCS_OFFSET       = 11'h202;
  localparam logic [10:0] PIN_REPL_OFFSET  = 11'h204;
  localparam logic [3:0]  DRIVE_ADDR_INDEX = 4'hf;
  localparam int          ADDR_W           = 11;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CHANGED_BIT  = 7;
  localparam int SIGNAL_CHANGE_ENABLE_BIT   = 6;
  localparam int BYTEONLY_BIT = 5;
  localparam int RSVD4_BIT    = 4;
  localparam int AUDIO_BIT    = 3;
  localparam int PWRDN_BIT    = 2;
  localparam int INTR_BIT     = 1;
  localparam int RDYCHG_BIT   = 5;
  localparam int WPCHG_BIT    = 4;
  localparam int RDY_MASK_BIT = 1;
  localparam int WP_MASK_BIT  = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CCS_RESET      = 8'h00;
  localparam logic [1:0] CHG_FLAGS_RESET = 2'h0;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic              ce_low_n;
    logic              ce_high_n;
    logic              reg_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
  } host_req_t;

  typedef struct packed {
    logic       low_valid;
    logic       high_valid;
    logic       odd_on_low;
  } lane_sel_t;

  typedef enum logic [1:0] {
    XFER_NONE,
    XFER_WORD,
    XFER_LOW,
    XFER_HIGH
  } xfer_kind_t;

endpackage

// [data_lane_decode.sv]
module data_lane_decode (
  input  wire logic                 i_a10,
  input  wire logic                 i_a0,
  input  wire logic                 i_low_byte_enable_n,
  input  wire logic                 i_high_byte_enable_n,
  input  wire logic                 i_reg_n,
  output      ccs_pkg::xfer_kind_t  o_kind,
  output      ccs_pkg::lane_sel_t   o_sel
);

  wire data_space;
  wire both_en;
  wire low_only;
  wire high_only;

  // other address bits ignored in the data window
  assign data_space = i_a10 & i_reg_n;
  assign both_en    = data_space & ~i_low_byte_enable_n & ~i_high_byte_enable_n;
  assign low_only   = data_space & ~i_low_byte_enable_n & i_high_byte_enable_n;
  assign high_only  = data_space & i_low_byte_enable_n & ~i_high_byte_enable_n;

  assign o_kind = both_en   ? ccs_pkg::XFER_WORD :
                  low_only  ? ccs_pkg::XFER_LOW  :
                  high_only ? ccs_pkg::XFER_HIGH :
                              ccs_pkg::XFER_NONE;

  assign o_sel.low_valid  = both_en | low_only;
  assign o_sel.high_valid = both_en | high_only;
  assign o_sel.odd_on_low = low_only & i_a0;

endmodule

// [card_config_status.sv]
module card_config_status (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_cfg_reset,
  input  wire ccs_pkg::host_req_t   i_req,
  input  wire logic [15:0]          i_wdata,
  output      logic [15:0]          o_rdata,
  output      logic                 o_rdata_low_oe,
  output      logic                 o_rdata_high_oe,
  input  wire logic [15:0]          i_data_word_rd,
  output      logic [15:0]          o_data_word_wr,
  output      logic                 o_data_wr_strobe,
  output      logic [1:0]           o_data_wr_lanes,
  output      logic                 o_data_rd_strobe,
  input  wire logic [7:0]           i_drive_address,
  input  wire logic                 i_io_mode,
  input  wire logic                 i_ready_state,
  input  wire logic                 i_write_protect_state,
  input  wire logic                 i_host_irq_level,
  input  wire logic                 i_cmd_power_down,
  output      logic                 o_status_changed_out_n,
  output      logic                 o_drive_activity_line_o,
  output      logic                 o_drive_activity_line_oe,
  output      logic                 o_power_down_request,
  output      logic                 o_power_down_active,
  output      logic                 o_byte_only_path
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic       signal_change_enable_r;
  logic       byte_only_path_r;
  logic       power_down_request_r;
  logic       ready_change_flag_r;
  logic       ready_change_flag_nxt;
  logic       wp_change_flag_r;
  logic       wp_change_flag_nxt;
  logic       ready_prev_r;
  logic       wp_prev_r;
  logic       prev_valid_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic       we_prev_n_r;

  ccs_pkg::xfer_kind_t kind;
  ccs_pkg::lane_sel_t  sel;

  data_lane_decode u_lanes (
    .i_a10                (i_req.addr[10]),
    .i_a0                 (i_req.addr[0]),
    .i_low_byte_enable_n  (i_req.ce_low_n),
    .i_high_byte_enable_n (i_req.ce_high_n),
    .i_reg_n              (i_req.reg_n),
    .o_kind               (kind),
    .o_sel                (sel)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire       attr_space;
  wire       ccs_hit;
  wire       pr_hit;
  wire       drv_hit;
  wire       rd_act;
  wire       wr_edge;
  wire       ccs_wr;
  wire       pr_wr;
  wire       changed;
  wire       ready_toggle;
  wire       wp_toggle;
  wire [7:0] ccs_view;
  wire [7:0] pr_view;

  assign attr_space = ~i_req.reg_n & ~i_req.ce_low_n;
  assign ccs_hit    = attr_space & (i_req.addr == ccs_pkg::CCS_OFFSET);
  assign pr_hit     = attr_space & (i_req.addr == ccs_pkg::PIN_REPL_OFFSET);
  assign drv_hit    = i_req.reg_n & ~i_req.addr[10] & i_req.ce_low_n & ~i_req.ce_high_n
                      & (i_req.addr[3:0] == ccs_pkg::DRIVE_ADDR_INDEX);
  assign rd_act     = ~i_req.oe_n;
  // one write per strobe, taken on the falling edge of write enable
  assign wr_edge    = we_prev_n_r & ~i_req.we_n;
  assign ccs_wr     = ccs_hit & wr_edge;
  assign pr_wr      = pr_hit & wr_edge;

  assign changed = ready_change_flag_r | wp_change_flag_r;

  // bit 4, bit 3 and bit 0 are constant zero
  assign ccs_view = {changed, signal_change_enable_r, byte_only_path_r,
                     1'b0, 1'b0,
                     power_down_request_r, i_host_irq_level, 1'b0};
  assign pr_view  = {2'b00, ready_change_flag_r, wp_change_flag_r,
                     2'b00, i_ready_state, i_write_protect_state};

  assign ready_toggle = prev_valid_r & (ready_prev_r != i_ready_state);
  assign wp_toggle    = prev_valid_r & (wp_prev_r != i_write_protect_state);

  // shared by both change flags; the mask bit gates the host write
  function automatic logic flag_next(input logic toggle, input logic wr, input logic mask,
                                     input logic val, input logic cur);
    if (toggle) begin
      return 1'b1;
    end else if (wr && mask) begin
      return val;
    end
    return cur;
  endfunction

  // set wins over a host clear in the same cycle
  assign ready_change_flag_nxt = flag_next(ready_toggle, pr_wr,
                                           i_wdata[ccs_pkg::RDY_MASK_BIT],
                                           i_wdata[ccs_pkg::RDYCHG_BIT],
                                           ready_change_flag_r);
  assign wp_change_flag_nxt    = flag_next(wp_toggle, pr_wr,
                                           i_wdata[ccs_pkg::WP_MASK_BIT],
                                           i_wdata[ccs_pkg::WPCHG_BIT],
                                           wp_change_flag_r);

  always_comb begin
    rdata_nxt = 16'h0000;
    if (ccs_hit) begin
      rdata_nxt = {8'h00, ccs_view};
    end else if (pr_hit) begin
      rdata_nxt = {8'h00, pr_view};
    end else if (drv_hit) begin
      rdata_nxt = {i_drive_address, 8'h00};
    end else begin
      case (kind)
        ccs_pkg::XFER_WORD: rdata_nxt = i_data_word_rd;
        ccs_pkg::XFER_LOW:  rdata_nxt = {8'h00, sel.odd_on_low ?
                                         i_data_word_rd[15:8] : i_data_word_rd[7:0]};
        ccs_pkg::XFER_HIGH: rdata_nxt = {i_data_word_rd[15:8], 8'h00};
        default:            rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_cfg_reset) begin
      signal_change_enable_r <= ccs_pkg::CCS_RESET[ccs_pkg::SIGNAL_CHANGE_ENABLE_BIT];
      byte_only_path_r       <= ccs_pkg::CCS_RESET[ccs_pkg::BYTEONLY_BIT];
      power_down_request_r   <= ccs_pkg::CCS_RESET[ccs_pkg::PWRDN_BIT];
    end else if (ccs_wr) begin
      // bits 7, 4, 3, 1, 0 are not stored
      signal_change_enable_r <= i_wdata[ccs_pkg::SIGNAL_CHANGE_ENABLE_BIT];
      byte_only_path_r       <= i_wdata[ccs_pkg::BYTEONLY_BIT];
      power_down_request_r   <= i_wdata[ccs_pkg::PWRDN_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ready_change_flag_r <= ccs_pkg::CHG_FLAGS_RESET[1];
      wp_change_flag_r    <= ccs_pkg::CHG_FLAGS_RESET[0];
      ready_prev_r        <= 1'b0;
      wp_prev_r           <= 1'b0;
      prev_valid_r        <= 1'b0;
      we_prev_n_r         <= 1'b1;
      rdata_r             <= 16'h0000;
    end else begin
      ready_change_flag_r <= ready_change_flag_nxt;
      wp_change_flag_r    <= wp_change_flag_nxt;
      ready_prev_r        <= i_ready_state;
      wp_prev_r           <= i_write_protect_state;
      prev_valid_r        <= 1'b1;
      we_prev_n_r         <= i_req.we_n;
      rdata_r             <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata         = rdata_r;
  assign o_rdata_low_oe  = rd_act & (ccs_hit | pr_hit | sel.low_valid);
  assign o_rdata_high_oe = rd_act & (drv_hit | sel.high_valid);

  // write to drive address slot falls through: no strobe
  assign o_data_word_wr   = i_wdata;
  assign o_data_wr_strobe = wr_edge & (sel.low_valid | sel.high_valid);
  assign o_data_wr_lanes  = {sel.high_valid, sel.low_valid};
  assign o_data_rd_strobe = rd_act & (sel.low_valid | sel.high_valid);

  // memory mode keeps the pin high; only i/o mode signals changes
  assign o_status_changed_out_n = ~(i_io_mode & signal_change_enable_r & changed);

  // audio unsupported: pin never driven
  assign o_drive_activity_line_o  = 1'b0;
  assign o_drive_activity_line_oe = 1'b0;

  assign o_power_down_request = power_down_request_r;
  // command power-down stays available regardless of the bit
  assign o_power_down_active  = power_down_request_r | i_cmd_power_down;
  assign o_byte_only_path     = byte_only_path_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_ccs_write;
    ccs_wr;
  endsequence

  sequence s_ready_clear;
    pr_wr && i_wdata[ccs_pkg::RDY_MASK_BIT] && !i_wdata[ccs_pkg::RDYCHG_BIT];
  endsequence

  sequence s_wp_clear;
    pr_wr && i_wdata[ccs_pkg::WP_MASK_BIT] && !i_wdata[ccs_pkg::WPCHG_BIT];
  endsequence

  chk_signal_change_enable_gates_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_io_mode && !signal_change_enable_r) |-> o_status_changed_out_n)
    else $error("status changed asserted while enable clear");

  chk_changed_drives_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_io_mode && signal_change_enable_r && (ready_change_flag_r || wp_change_flag_r))
      |-> !o_status_changed_out_n)
    else $error("status changed not asserted");

  chk_ccs_write_stores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_ccs_write ##0 !i_cfg_reset) |=> (power_down_request_r == $past(i_wdata[2])))
    else $error("power-down bit not stored");

  chk_byteonly_stores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_ccs_write ##0 !i_cfg_reset) |=> (o_byte_only_path == $past(i_wdata[5])))
    else $error("byte-only bit not stored");

  chk_ready_toggle_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ready_toggle |=> ready_change_flag_r)
    else $error("ready change flag not set");

  chk_wp_toggle_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wp_toggle |=> wp_change_flag_r)
    else $error("wp change flag not set");

  chk_ccs_read_view: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ccs_hit |=> (o_rdata[1] == $past(i_host_irq_level)) && (o_rdata[4:3] == 2'b00)
                && (o_rdata[0] == 1'b0))
    else $error("config status read view wrong");

  chk_cfg_reset_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cfg_reset |=> !signal_change_enable_r && !byte_only_path_r && !power_down_request_r)
    else $error("config reset did not clear bits");

  chk_odd_low_lane: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (kind == ccs_pkg::XFER_LOW && i_req.addr[0] && !ccs_hit && !pr_hit && !drv_hit)
      |=> (o_rdata[7:0] == $past(i_data_word_rd[15:8])))
    else $error("odd byte not steered to low lane");

  chk_high_only_lane: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (kind == ccs_pkg::XFER_HIGH && !drv_hit)
      |=> (o_rdata == {$past(i_data_word_rd[15:8]), 8'h00}))
    else $error("high lane transfer wrong");

  chk_drive_addr_nowrite: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    drv_hit |-> !o_data_wr_strobe)
    else $error("drive address slot took a write");

  chk_ready_host_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_ready_clear ##0 !ready_toggle) |=> !ready_change_flag_r)
    else $error("ready change flag not cleared by host");

  chk_wp_host_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_wp_clear ##0 !wp_toggle) |=> !wp_change_flag_r)
    else $error("wp change flag not cleared by host");

  chk_memory_mode_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_io_mode |-> o_status_changed_out_n)
    else $error("status changed asserted in memory mode");

  chk_summary_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ccs_hit |=> (o_rdata[7] == $past(changed)))
    else $error("changed bit does not follow the flags");

  chk_word_lanes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (kind == ccs_pkg::XFER_WORD) |=> (o_rdata == $past(i_data_word_rd)))
    else $error("word transfer wrong");

  chk_even_low_lane: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (kind == ccs_pkg::XFER_LOW && !i_req.addr[0])
      |=> (o_rdata == {8'h00, $past(i_data_word_rd[7:0])}))
    else $error("even byte not steered to low lane");

  chk_drive_addr_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    drv_hit |=> (o_rdata == {$past(i_drive_address), 8'h00}))
    else $error("drive address read wrong");

  chk_single_wr_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_data_wr_strobe |=> !o_data_wr_strobe)
    else $error("write strobe longer than one cycle");

  chk_cmd_power_down: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cmd_power_down |-> o_power_down_active)
    else $error("command power-down not honoured");

endmodule

// [host_bus_model.sv]
module host_bus_model (
  input  wire logic               i_clk,
  input  wire logic [15:0]        i_rdata,
  output      ccs_pkg::host_req_t o_req,
  output      logic [15:0]        o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // idle bus
  // ----------------------------------------
  initial begin
    o_req   = '1;
    o_wdata = 16'h0000;
  end

  // ----------------------------------------
  // one access, held across its sampling edge
  // ----------------------------------------
  // transfer width stays the command set's business, not this bus
  task automatic cycle(input logic reg_n, input logic ce_l, input logic ce_h,
                       input logic [10:0] a, input logic wr, input logic [15:0] wd,
                       output logic [15:0] rd);
    @(negedge i_clk);
    o_req.reg_n    = reg_n;
    o_req.ce_low_n = ce_l;
    o_req.ce_high_n = ce_h;
    o_req.oe_n     = wr;
    o_req.we_n     = !wr;
    o_req.addr     = a;
    o_wdata        = wd;
    @(posedge i_clk);
    @(negedge i_clk);
    rd = i_rdata;
    // released address and data show inverted values, not the last ones
    o_req   = '{ce_low_n: 1'b1, ce_high_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1,
                we_n: 1'b1, addr: ~a};
    o_wdata = ~wd;
  endtask
endmodule

// [card_config_status_and_data_decode_test.sv]
module card_config_status_and_data_decode_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic               i_clk = 1'b0;
  logic               i_rst_n = 1'b0;
  logic               i_cfg_reset = 1'b0;
  ccs_pkg::host_req_t req;
  logic [15:0]        wdata;
  logic [15:0]        rdata;
  logic               low_oe, high_oe, wr_strobe, rd_strobe;
  logic [15:0]        data_rd = 16'ha5c3;
  logic [15:0]        data_wr;
  logic [1:0]         lanes, lanes_seen;
  logic [7:0]         drive_addr = 8'h3c;
  logic               io_mode = 1'b0, rdy = 1'b0, wp = 1'b0, irq = 1'b0, cmd_pd = 1'b0;
  logic               chg_n, act_o, act_oe, pd_req, pd_act, byte_only;
  logic [15:0]        rd_v;
  logic [2:0]         oe_seen;
  logic [15:0]        wr_seen;
  int                 miscompares = 0, n_tests = 0, strobes = 0, cyc = 0;

  always #2 i_clk = ~i_clk;

  host_bus_model host (.i_clk(i_clk), .i_rdata(rdata), .o_req(req), .o_wdata(wdata));

  card_config_status dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_reset(i_cfg_reset), .i_req(req),
    .i_wdata(wdata), .o_rdata(rdata), .o_rdata_low_oe(low_oe), .o_rdata_high_oe(high_oe),
    .i_data_word_rd(data_rd), .o_data_word_wr(data_wr), .o_data_wr_strobe(wr_strobe),
    .o_data_wr_lanes(lanes), .o_data_rd_strobe(rd_strobe), .i_drive_address(drive_addr),
    .i_io_mode(io_mode), .i_ready_state(rdy), .i_write_protect_state(wp),
    .i_host_irq_level(irq), .i_cmd_power_down(cmd_pd), .o_status_changed_out_n(chg_n),
    .o_drive_activity_line_o(act_o), .o_drive_activity_line_oe(act_oe),
    .o_power_down_request(pd_req), .o_power_down_active(pd_act),
    .o_byte_only_path(byte_only));

  // ----------------------------------------
  // monitors and helpers
  // ----------------------------------------
  always @(posedge i_clk) begin
    cyc++;
    if (wr_strobe === 1'b1) strobes++;
    if (req.we_n === 1'b0) lanes_seen <= lanes;
    if (req.we_n === 1'b0) wr_seen <= data_wr;
    if (req.oe_n === 1'b0) oe_seen <= {high_oe, low_oe, rd_strobe};
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic attr(input logic [10:0] a, input logic wr, input logic [15:0] wd);
    host.cycle(1'b0, 1'b0, 1'b1, a, wr, wd, rd_v);
  endtask

  task automatic data(input logic ce_l, input logic ce_h, input logic a10, input logic [3:0] a,
                      input logic wr);
    host.cycle(1'b1, ce_l, ce_h, {a10, 6'h00, a}, wr, 16'h1234, rd_v);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    attr(11'h202, 1'b0, 16'h0000);
    chk("ccs reset", 16'h0000, rd_v);
    chk("chg_n idle", 16'h0001, {15'h0000, chg_n});
    attr(11'h300, 1'b0, 16'h0000);
    chk("unmapped", 16'h0000, rd_v);
    $display("test reset done");
  endtask

  task automatic t_ctrl_bits();
    attr(11'h202, 1'b1, 16'h00ee);
    attr(11'h202, 1'b0, 16'h0000);
    chk("ccs rw", 16'h0064, rd_v);
    chk("ccs oe", 16'h0002, {13'h0000, oe_seen});
    chk("pins", 16'h0007, {13'h0000, pd_req, byte_only, pd_act});
    chk("activity", 16'h0000, {14'h0000, act_o, act_oe});
    @(negedge i_clk) i_cfg_reset = 1'b1;
    @(negedge i_clk) i_cfg_reset = 1'b0;
    attr(11'h202, 1'b0, 16'h0000);
    chk("cfg reset", 16'h0000, rd_v);
    $display("test ctrl bits done");
  endtask

  task automatic t_irq_pd();
    irq    = 1'b1;
    cmd_pd = 1'b1;
    attr(11'h202, 1'b0, 16'h0000);
    chk("irq mirror", 16'h0002, rd_v);
    chk("cmd pd", 16'h0001, {14'h0000, pd_req, pd_act});
    irq    = 1'b0;
    cmd_pd = 1'b0;
    attr(11'h202, 1'b0, 16'h0000);
    chk("irq drop", 16'h0000, rd_v);
    $display("test irq done");
  endtask

  task automatic t_flags();
    io_mode = 1'b1;
    attr(11'h202, 1'b1, 16'h0040);
    rdy = 1'b1;
    attr(11'h202, 1'b0, 16'h0000);
    chk("rdy change", 16'h00c0, rd_v);
    chk("chg_n on", 16'h0000, {15'h0000, chg_n});
    attr(11'h204, 1'b0, 16'h0000);
    chk("pin repl", 16'h0022, rd_v);
    attr(11'h202, 1'b1, 16'h0000);
    chk("chg_n gated", 16'h0001, {15'h0000, chg_n});
    attr(11'h204, 1'b1, 16'h0002);
    attr(11'h202, 1'b0, 16'h0000);
    chk("rdy cleared", 16'h0000, rd_v);
    wp = 1'b1;
    attr(11'h202, 1'b0, 16'h0000);
    chk("wp change", 16'h0080, rd_v);
    attr(11'h204, 1'b1, 16'h0001);
    attr(11'h202, 1'b0, 16'h0000);
    chk("wp cleared", 16'h0000, rd_v);
    io_mode = 1'b0;
    $display("test flags done");
  endtask

  task automatic t_data();
    logic [1:0] ce [4] = '{2'b00, 2'b01, 2'b01, 2'b10};
    logic [15:0] exp [4] = '{16'ha5c3, 16'h00a5, 16'h00c3, 16'ha500};
    logic [1:0] ln [4] = '{2'b11, 2'b01, 2'b01, 2'b10};
    for (int i = 0; i < 4; i++) begin
      data(ce[i][1], ce[i][0], 1'b1, {3'h7, i[0]}, 1'b0);
      chk("lane read", exp[i], rd_v);
      chk("read oe", {13'h0000, ln[i], 1'b1}, {13'h0000, oe_seen});
      strobes = 0;
      data(ce[i][1], ce[i][0], 1'b1, {3'h7, i[0]}, 1'b1);
      chk("lanes", {14'h0000, ln[i]}, {14'h0000, lanes_seen});
      chk("write data", 16'h1234, wr_seen);
      chk("strobe", 16'h0001, strobes[15:0]);
    end
    $display("test data done");
  endtask

  task automatic t_drive_addr();
    data(1'b1, 1'b0, 1'b0, 4'hf, 1'b0);
    chk("drive addr", {drive_addr, 8'h00}, {rd_v[15:8], 8'h00});
    chk("drive oe", 16'h0004, {13'h0000, oe_seen});
    strobes = 0;
    data(1'b1, 1'b0, 1'b0, 4'hf, 1'b1);
    chk("drive addr wr", 16'h0000, strobes[15:0]);
    $display("test drive address done");
  endtask

  // ----------------------------------------
  // closing
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) i_rst_n = 1'b1;
    t_reset();
    t_ctrl_bits();
    t_irq_pd();
    t_flags();
    t_data();
    t_drive_addr();
    test_done();
  end
endmodule
